// File: battery_mode_protection_ctrl.sv
// Operation
// R1: charger present, external above pack by 0.5V, charge current valid: charging mode.
// R2: load present and discharge current valid: discharging mode.
// R3: neither condition holds: standby mode.
// R4: shutdown after 48h standby, under-voltage, off key or external switch off.
// R5: wake from shutdown on charge, 48V, on key or external switch.
// R6: drive run lamp, fault lamp and four capacity lamps.
// R7: slow 0.25/3.75s, medium 0.5/0.5s, long 0.5/1.5s blink patterns.
// R8: capacity lamps fill from lowest by band; top lamp flashes while charging.
// R9: reset-key boot into standby only without protection; standby blinks run lamp.
// R10: discharging: run lamp long blink, fault lamp off, capacity shown; code long-blinks the fault lamp while alarm_det is set and no under-voltage.
// R11: discharge fault: stop discharge, fault lamp solid only, sleep after 48h idle; in charge mode code slow-blinks both run and fault lamps.
// R12: any cell over threshold: overcharge protection, charging blocked.
// R13: cell overcharge clears on cell recovery with charge below 96%, or discharge.
// R14: pack over threshold: overcharge protection, charging blocked.
// R15: pack overcharge clears on pack recovery with charge below 96%.
// R16: cell under threshold: block discharge, stay awake one minute, then shut down.
// R17: pack under threshold: over-discharge protection, discharge blocked.
// R18: charging releases over-discharge; reset key rechecks pack recovery.
// R19: wake after under-voltage shutdown holds output one minute, no discharge; code holds only on on-key, reset-key or charger wake.
// R20: all blink patterns come from one free-running tick counter.
// R21: each protection flag set and released independently.
`timescale 1ns/100ps
`default_nettype none
module battery_mode_protection_ctrl import bmu_pkg::*; #(
  parameter int unsigned TICK_LEN = TICK_CYCLES,
  parameter int unsigned STANDBY_LEN = STANDBY_TICKS,
  parameter int unsigned UV_HOLD_LEN = UV_HOLD_TICKS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // charger, load and front-end comparators
  input wire logic charger_det,
  input wire logic ext_above_pack,
  input wire logic chg_cur_ok,
  input wire logic load_det,
  input wire logic dsg_cur_ok,
  input wire logic cell_ov_det,
  input wire logic cell_ov_clr,
  input wire logic pack_ov_det,
  input wire logic pack_ov_clr,
  input wire logic cell_uv_det,
  input wire logic pack_uv_det,
  input wire logic pack_uv_clr,
  input wire logic dsg_fault,
  input wire logic alarm_det,
  // wake and shutdown sources
  input wire logic key_on,
  input wire logic key_off,
  input wire logic reset_key,
  input wire logic ext_switch,
  input wire logic wake_48v,
  // power path
  output logic power_hold,
  output logic chg_enable,
  output logic dsg_enable,
  // lamps
  output logic run_lamp,
  output logic fault_lamp_out,
  output logic capacity_lamp_0,
  output logic capacity_lamp_1,
  output logic capacity_lamp_2,
  output logic capacity_lamp_3
);
  logic [N_SYNC-1:0] s1_q, s2_q, s3_q, raw;
  logic charger_s, ext_above_s, chg_cur_s, load_s, dsg_cur_s, cell_ov_s, cell_ov_clr_s, pack_ov_s;
  logic pack_ov_clr_s, cell_uv_s, pack_uv_s, pack_uv_clr_s, dsg_fault_s, alarm_s, wake_48v_s;
  logic key_on_r, key_off_r, reset_r, ext_rise, ext_fall;
  logic tick, blink_slow, blink_medium, blink_long;
  mode_e mode_q;
  logic awake, chg_cond, dsg_cond, soc_low, prot_now, wake_ok, shut_req;
  logic cell_ov_q, pack_ov_q, cell_uv_q, pack_uv_q, ov_any, uv_any, uv_shut_q;
  logic [IDLE_W-1:0] idle_q;
  logic [HOLD_W-1:0] uv_cnt_q, hold_q;
  logic idle_run, idle_done, uv_done, hold_act, show;
  logic ext_en_q, sw_off_q;
  logic [6:0] soc_q;
  logic [1:0] band;
  logic [3:0] cap_d;
  logic aw_got_q, w_got_q, wr_fire;
  logic [31:0] awaddr_q, wdata_q;
  logic [3:0] wstrb_q;

  function automatic sel_e reg_sel(input logic [31:0] addr);
    if (addr[31:ADDR_W] != '0) reg_sel = SEL_NONE;
    else if (addr[ADDR_W-1:0] == ADDR_CTRL) reg_sel = SEL_CTRL;
    else if (addr[ADDR_W-1:0] == ADDR_SOC) reg_sel = SEL_SOC;
    else if (addr[ADDR_W-1:0] == ADDR_STATUS) reg_sel = SEL_STATUS;
    else reg_sel = SEL_NONE;
  endfunction

  // ============================================================
  // input synchronisers
  assign raw = {wake_48v, ext_switch, reset_key, key_off, key_on, alarm_det, dsg_fault, pack_uv_clr,
                pack_uv_det, cell_uv_det, pack_ov_clr, pack_ov_det, cell_ov_clr, cell_ov_det, dsg_cur_ok,
                load_det, chg_cur_ok, ext_above_pack, charger_det};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign {wake_48v_s, alarm_s, dsg_fault_s, pack_uv_clr_s, pack_uv_s, cell_uv_s, pack_ov_clr_s, pack_ov_s,
          cell_ov_clr_s, cell_ov_s, dsg_cur_s, load_s, chg_cur_s, ext_above_s, charger_s} =
         {s2_q[18], s2_q[13:0]};
  assign key_on_r = s2_q[14] & ~s3_q[14];
  assign key_off_r = s2_q[15] & ~s3_q[15];
  assign reset_r = s2_q[16] & ~s3_q[16];
  assign ext_rise = s2_q[17] & ~s3_q[17];
  assign ext_fall = ~s2_q[17] & s3_q[17];

  blink_gen #(.TICK_LEN(TICK_LEN)) u_blink (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .blink_slow(blink_slow),
    .blink_medium(blink_medium),
    .blink_long(blink_long)
  );

  // ============================================================
  // mode selection
  assign awake = mode_q != MODE_SHUTDOWN;
  assign chg_cond = charger_s & ext_above_s & chg_cur_s; // [R1]
  assign dsg_cond = load_s & dsg_cur_s; // [R2]
  assign soc_low = soc_q < SOC_RECOVER;
  assign ov_any = cell_ov_q | pack_ov_q;
  assign uv_any = cell_uv_q | pack_uv_q;
  assign prot_now = cell_ov_s | pack_ov_s | cell_uv_s | pack_uv_s | dsg_fault_s;
  assign wake_ok = !awake & (charger_s | wake_48v_s | key_on_r | (ext_en_q & ext_rise) // [R5]
                   | (reset_r & !prot_now)); // [R9]
  assign shut_req = idle_done | uv_done | key_off_r | (ext_en_q & ext_fall) | sw_off_q; // [R4]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= MODE_SHUTDOWN;
    end else begin
      case (mode_q)
        MODE_SHUTDOWN: begin
          if (wake_ok) mode_q <= MODE_STANDBY; // [R5] [R9]
        end
        MODE_STANDBY, MODE_CHARGE, MODE_DISCHARGE: begin
          if (shut_req) mode_q <= MODE_SHUTDOWN; // [R4]
          else if (chg_cond) mode_q <= MODE_CHARGE; // [R1]
          else if (dsg_cond) mode_q <= MODE_DISCHARGE; // [R2]
          else mode_q <= MODE_STANDBY; // [R3]
        end
        default: mode_q <= MODE_SHUTDOWN;
      endcase
    end
  end

  // ============================================================
  // idle, under-voltage-hold and output-hold timers
  assign idle_run = awake & ((mode_q == MODE_STANDBY & !prot_now) | (dsg_fault_s & !charger_s)); // [R4] [R11]
  assign idle_done = idle_run & tick & (idle_q == IDLE_W'(STANDBY_LEN - 1));
  assign uv_done = awake & uv_any & tick & (uv_cnt_q == HOLD_W'(UV_HOLD_LEN - 1)); // [R16]
  assign hold_act = hold_q != '0;

  always_ff @(posedge aclk) begin
    if (!aresetn || !idle_run) begin
      idle_q <= '0;
    end else if (tick) begin
      idle_q <= idle_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !(awake && uv_any)) begin
      uv_cnt_q <= '0;
    end else if (tick) begin
      uv_cnt_q <= uv_cnt_q + 1'b1; // [R16]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uv_shut_q <= 1'b0;
      hold_q <= '0;
    end else if (uv_done) begin
      uv_shut_q <= 1'b1;
      hold_q <= '0;
    end else if (wake_ok) begin
      uv_shut_q <= 1'b0;
      if (uv_shut_q && (key_on_r || reset_r || charger_s)) hold_q <= HOLD_W'(UV_HOLD_LEN); // [R19]
    end else if (tick && hold_act) begin
      hold_q <= hold_q - 1'b1;
    end
  end

  // ============================================================
  // protection flags, set wins over release
  always_ff @(posedge aclk) begin
    if (!aresetn) cell_ov_q <= 1'b0;
    else if (cell_ov_s) cell_ov_q <= 1'b1; // [R12] [R21]
    else if ((cell_ov_clr_s && soc_low) || dsg_cond) cell_ov_q <= 1'b0; // [R13]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) pack_ov_q <= 1'b0;
    else if (pack_ov_s) pack_ov_q <= 1'b1; // [R14] [R21]
    else if (pack_ov_clr_s && soc_low) pack_ov_q <= 1'b0; // [R15]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) cell_uv_q <= 1'b0;
    else if (cell_uv_s) cell_uv_q <= 1'b1; // [R16] [R21]
    else if (chg_cond || (reset_r && pack_uv_clr_s)) cell_uv_q <= 1'b0; // [R18]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) pack_uv_q <= 1'b0;
    else if (pack_uv_s) pack_uv_q <= 1'b1; // [R17] [R21]
    else if (chg_cond || (reset_r && pack_uv_clr_s)) pack_uv_q <= 1'b0; // [R18]
  end

  // ============================================================
  // power path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_hold <= 1'b0;
      chg_enable <= 1'b0;
      dsg_enable <= 1'b0;
    end else begin
      power_hold <= awake | hold_act; // [R16] [R19]
      chg_enable <= awake & !ov_any; // [R9] [R12] [R14]
      dsg_enable <= awake & !uv_any & !dsg_fault_s & !hold_act; // [R11] [R17] [R19]
    end
  end

  // ============================================================
  // lamps
  assign band = (soc_q >= SOC_BAND3) ? 2'h3 : (soc_q >= SOC_BAND2) ? 2'h2 : (soc_q >= SOC_BAND1) ? 2'h1 : 2'h0;
  assign show = (mode_q == MODE_CHARGE & !ov_any & !dsg_fault_s) | (mode_q == MODE_DISCHARGE & !dsg_fault_s & !uv_any);

  always_comb begin
    cap_d = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (show && 2'(i) < band) cap_d[i] = 1'b1; // [R8]
      else if (show && 2'(i) == band) cap_d[i] = (mode_q == MODE_CHARGE) ? blink_medium : 1'b1; // [R8]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_lamp <= 1'b0;
      fault_lamp_out <= 1'b0;
      {capacity_lamp_3, capacity_lamp_2, capacity_lamp_1, capacity_lamp_0} <= 4'h0;
    end else begin
      {capacity_lamp_3, capacity_lamp_2, capacity_lamp_1, capacity_lamp_0} <= cap_d; // [R6]
      case (mode_q)
        MODE_STANDBY: begin
          run_lamp <= dsg_fault_s ? 1'b0 : blink_slow; // [R9] [R11]
          fault_lamp_out <= dsg_fault_s; // [R11]
        end
        MODE_CHARGE: begin
          run_lamp <= (ov_any | dsg_fault_s) ? blink_slow : 1'b1;
          fault_lamp_out <= dsg_fault_s ? blink_slow : (alarm_s ? blink_medium : 1'b0);
        end
        MODE_DISCHARGE: begin
          run_lamp <= (dsg_fault_s | uv_any) ? 1'b0 : blink_long; // [R10] [R11]
          fault_lamp_out <= dsg_fault_s | (!uv_any & alarm_s & blink_long); // [R10] [R11]
        end
        default: begin
          run_lamp <= 1'b0;
          fault_lamp_out <= 1'b0;
        end
      endcase
    end
  end

  // ============================================================
  // axi4-lite write
  assign wr_fire = aw_got_q & w_got_q & !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      aw_got_q <= 1'b0;
      awaddr_q <= 32'h0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_got_q <= 1'b1;
      awaddr_q <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
      aw_got_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      w_got_q <= 1'b0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_got_q <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
      w_got_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= (reg_sel(awaddr_q) == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_en_q <= CTRL_EXT_EN_RST;
      soc_q <= SOC_RST;
      sw_off_q <= 1'b0;
    end else begin
      sw_off_q <= 1'b0;
      if (wr_fire && wstrb_q[0] && reg_sel(awaddr_q) == SEL_CTRL) begin
        ext_en_q <= wdata_q[0];
        sw_off_q <= wdata_q[1];
      end
      if (wr_fire && wstrb_q[0] && reg_sel(awaddr_q) == SEL_SOC) soc_q <= wdata_q[6:0];
    end
  end

  // ============================================================
  // axi4-lite read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      case (reg_sel(araddr))
        SEL_CTRL: rdata <= {31'h0, ext_en_q};
        SEL_SOC: rdata <= {25'h0, soc_q};
        SEL_STATUS: rdata <= {22'h0, dsg_enable, chg_enable, uv_shut_q, hold_act, pack_uv_q, cell_uv_q,
                              pack_ov_q, cell_ov_q, mode_q};
        default: begin
          rdata <= 32'h0;
          rresp <= RESP_DECERR;
        end
      endcase
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

  // ============================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_chg_mode;
    (awake && !shut_req && chg_cond) |=> (mode_q == MODE_CHARGE);
  endproperty
  a_chg_mode: assert property (p_chg_mode) else $error("charge mode not entered"); // [R1]

  property p_dsg_mode;
    (awake && !shut_req && !chg_cond && dsg_cond) |=> (mode_q == MODE_DISCHARGE);
  endproperty
  a_dsg_mode: assert property (p_dsg_mode) else $error("discharge mode not entered"); // [R2]

  property p_stby_mode;
    (awake && !shut_req && !chg_cond && !dsg_cond) |=> (mode_q == MODE_STANDBY);
  endproperty
  a_stby_mode: assert property (p_stby_mode) else $error("standby mode not entered"); // [R3]

  property p_key_off;
    (awake && key_off_r) |=> (mode_q == MODE_SHUTDOWN) ##1 !power_hold;
  endproperty
  a_key_off: assert property (p_key_off) else $error("off key did not shut down"); // [R4]

  property p_cell_ov;
    cell_ov_s |-> ##2 !chg_enable;
  endproperty
  a_cell_ov: assert property (p_cell_ov) else $error("charging not blocked on cell overcharge"); // [R12]

  property p_cell_ov_rel;
    (cell_ov_q && !cell_ov_s && dsg_cond) |=> !cell_ov_q;
  endproperty
  a_cell_ov_rel: assert property (p_cell_ov_rel) else $error("cell overcharge not released"); // [R13]

  property p_pack_ov;
    pack_ov_s |=> pack_ov_q ##1 !chg_enable;
  endproperty
  a_pack_ov: assert property (p_pack_ov) else $error("charging not blocked on pack overcharge"); // [R14]

  property p_pack_uv;
    pack_uv_s |-> ##2 !dsg_enable;
  endproperty
  a_pack_uv: assert property (p_pack_uv) else $error("discharge not blocked on pack under-voltage"); // [R17]

  property p_hold;
    hold_act |=> (!dsg_enable && power_hold);
  endproperty
  a_hold: assert property (p_hold) else $error("discharge during output hold"); // [R19]

  property p_dsg_fault;
    (mode_q == MODE_DISCHARGE && dsg_fault_s) |=> (fault_lamp_out && !run_lamp && !capacity_lamp_0);
  endproperty
  a_dsg_fault: assert property (p_dsg_fault) else $error("wrong lamps on discharge fault"); // [R11]

  c_charge: cover property (mode_q == MODE_CHARGE && capacity_lamp_0);
  c_discharge: cover property (mode_q == MODE_DISCHARGE && dsg_enable);
  c_uv_shut: cover property (uv_done ##1 mode_q == MODE_SHUTDOWN);
  c_hold: cover property (hold_act && awake);
endmodule // battery_mode_protection_ctrl
`default_nettype wire

// File: blink_gen.sv
`timescale 1ns/100ps
`default_nettype none
module blink_gen import bmu_pkg::*; #(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // quarter-second tick and patterns
  output logic tick,
  output logic blink_slow,
  output logic blink_medium,
  output logic blink_long
);
  logic [TICK_W-1:0] div_q;
  logic [PHASE_W-1:0] phase_q;

  function automatic logic pat_on(input logic [PHASE_W-1:0] ph, input logic [PHASE_W-1:0] on_t,
                                  input logic [PHASE_W-1:0] mask);
    pat_on = (ph & mask) < on_t;
  endfunction

  // ============================================================
  // divider and shared phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
      tick <= 1'b0;
    end else if (div_q == TICK_W'(TICK_LEN - 1)) begin
      div_q <= '0;
      tick <= 1'b1;
    end else begin
      div_q <= div_q + 1'b1;
      tick <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= '0;
    end else if (tick) begin
      phase_q <= phase_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_slow <= 1'b0;
      blink_medium <= 1'b0;
      blink_long <= 1'b0;
    end else begin
      blink_slow <= pat_on(phase_q, SLOW_ON_T, SLOW_MASK); // [R7] [R20]
      blink_medium <= pat_on(phase_q, MED_ON_T, MED_MASK); // [R7] [R20]
      blink_long <= pat_on(phase_q, LONG_ON_T, LONG_MASK); // [R7] [R20]
    end
  end

  // ============================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_in_phase;
    (phase_q == 4'h0) |=> (blink_slow && blink_medium && blink_long);
  endproperty
  a_in_phase: assert property (p_in_phase) else $error("patterns not in phase"); // [R20]

  property p_all_off;
    (phase_q == 4'h2) |=> (!blink_slow && !blink_medium && !blink_long);
  endproperty
  a_all_off: assert property (p_all_off) else $error("pattern on in off phase"); // [R7]
endmodule // blink_gen
`default_nettype wire

// File: bmu_pkg.sv
`default_nettype none
// ============================================================
// timing
package bmu_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TICK_MS = 250;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned STANDBY_HOURS = 48;
  localparam int unsigned STANDBY_TICKS = STANDBY_HOURS * 3600 * 1000 / TICK_MS;
  localparam int unsigned UV_HOLD_S = 60;
  localparam int unsigned UV_HOLD_TICKS = UV_HOLD_S * 1000 / TICK_MS;
  localparam int unsigned TICK_W = 24;
  localparam int unsigned IDLE_W = 20;
  localparam int unsigned HOLD_W = 8;
  // ============================================================
  // blink patterns, in milliseconds and ticks
  localparam int unsigned PHASE_W = 4;
  localparam int unsigned SLOW_ON_MS = 250;
  localparam int unsigned SLOW_OFF_MS = 3750;
  localparam int unsigned MED_ON_MS = 500;
  localparam int unsigned MED_OFF_MS = 500;
  localparam int unsigned LONG_ON_MS = 500;
  localparam int unsigned LONG_OFF_MS = 1500;
  localparam logic [PHASE_W-1:0] SLOW_ON_T = PHASE_W'(SLOW_ON_MS / TICK_MS);
  localparam logic [PHASE_W-1:0] SLOW_MASK = PHASE_W'((SLOW_ON_MS + SLOW_OFF_MS) / TICK_MS - 1);
  localparam logic [PHASE_W-1:0] MED_ON_T = PHASE_W'(MED_ON_MS / TICK_MS);
  localparam logic [PHASE_W-1:0] MED_MASK = PHASE_W'((MED_ON_MS + MED_OFF_MS) / TICK_MS - 1);
  localparam logic [PHASE_W-1:0] LONG_ON_T = PHASE_W'(LONG_ON_MS / TICK_MS);
  localparam logic [PHASE_W-1:0] LONG_MASK = PHASE_W'((LONG_ON_MS + LONG_OFF_MS) / TICK_MS - 1);
  // ============================================================
  // charge level bands
  localparam logic [6:0] SOC_BAND1 = 7'h19;
  localparam logic [6:0] SOC_BAND2 = 7'h32;
  localparam logic [6:0] SOC_BAND3 = 7'h4B;
  localparam logic [6:0] SOC_RECOVER = 7'h60;
  // ============================================================
  // register map
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_SOC = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;
  localparam logic CTRL_EXT_EN_RST = 1'h1;
  localparam logic [6:0] SOC_RST = 7'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int unsigned N_SYNC = 19;
  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'b00,
    MODE_STANDBY = 2'b01,
    MODE_CHARGE = 2'b10,
    MODE_DISCHARGE = 2'b11
  } mode_e;
  typedef enum logic [1:0] {
    SEL_CTRL = 2'b00,
    SEL_SOC = 2'b01,
    SEL_STATUS = 2'b10,
    SEL_NONE = 2'b11
  } sel_e;
endpackage
`default_nettype wire

// File: far_side_model.sv
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
  // requests from the bench and path enables from the device
  input wire logic want_chg,
  input wire logic want_load,
  input wire logic chg_enable,
  input wire logic dsg_enable,
  // pins toward the device
  output logic charger_det,
  output logic ext_above_pack,
  output logic chg_cur_ok,
  output logic load_det,
  output logic dsg_cur_ok
);
  // ============================================================
  // current only flows through an enabled path
  assign charger_det = want_chg;
  assign ext_above_pack = want_chg;
  assign chg_cur_ok = want_chg & chg_enable;
  assign load_det = want_load;
  assign dsg_cur_ok = want_load & dsg_enable;
endmodule // far_side_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench import bmu_pkg::*;;
  logic aclk = 1'h0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [3:0] wstrb, cap;
  logic [1:0] bresp, rresp, r;
  logic charger_det, ext_above_pack, chg_cur_ok, load_det, dsg_cur_ok, want_chg, want_load, dsg_fault;
  logic cell_ov_det, cell_ov_clr, pack_ov_det, pack_ov_clr, cell_uv_det, pack_uv_det, pack_uv_clr;
  logic alarm_det, key_on, key_off, reset_key, ext_switch, wake_48v, power_hold, chg_enable, dsg_enable;
  logic run_lamp, fault_lamp_out, capacity_lamp_0, capacity_lamp_1, capacity_lamp_2, capacity_lamp_3;
  int mismatches, checks, soc_q[$];
  battery_mode_protection_ctrl #(.TICK_LEN(4), .STANDBY_LEN(16), .UV_HOLD_LEN(4)) u_battery_mode_protection_ctrl (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .charger_det, .ext_above_pack, .chg_cur_ok,
    .load_det, .dsg_cur_ok, .cell_ov_det, .cell_ov_clr, .pack_ov_det, .pack_ov_clr, .cell_uv_det, .pack_uv_det,
    .pack_uv_clr, .dsg_fault, .alarm_det, .key_on, .key_off, .reset_key, .ext_switch, .wake_48v, .power_hold,
    .chg_enable, .dsg_enable, .run_lamp, .fault_lamp_out, .capacity_lamp_0, .capacity_lamp_1, .capacity_lamp_2,
    .capacity_lamp_3);
  far_side_model u_far_side_model (.want_chg, .want_load, .chg_enable, .dsg_enable, .charger_det,
    .ext_above_pack, .chg_cur_ok, .load_det, .dsg_cur_ok);
  assign cap = {capacity_lamp_3, capacity_lamp_2, capacity_lamp_1, capacity_lamp_0};
  always #10 aclk = ~aclk;
  // ============================================================
  // bus and check tasks
  task automatic go(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!(bvalid && bready));
    bready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [31:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic st(input logic [31:0] m, input logic [31:0] exp);
    rd({28'h0, ADDR_STATUS});
    chk(d & m, exp);
  endtask
  function automatic logic [31:0] lamps(input int s);
    int b;
    b = (s >= 75) ? 3 : (s >= 50) ? 2 : (s >= 25) ? 1 : 0;
    return 32'((2 << b) - 1);
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ============================================================
  // scenarios
  initial begin
    void'($urandom(32'h99C7F674));
    {aresetn, awvalid, wvalid, bready, arvalid, rready, want_chg, want_load, dsg_fault} = '0;
    {cell_ov_det, cell_ov_clr, pack_ov_det, pack_ov_clr, cell_uv_det, pack_uv_det, pack_uv_clr} = '0;
    {alarm_det, key_on, key_off, reset_key, ext_switch, wake_48v, awaddr, wdata, araddr} = '0;
    wstrb = 4'hF;
    mismatches = 0;
    checks = 0;
    go(4);
    aresetn <= 1'h1;
    go(1);
    rd(32'h0);
    chk(d, 32'h1);
    rd(32'h10);
    chk({30'h0, r}, {30'h0, RESP_DECERR});
    st(32'h3, 32'h0);
    chk({26'h0, fault_lamp_out, run_lamp, cap}, 32'h0);
    key_on <= 1'h1;
    go(8);
    key_on <= 1'h0;
    st(32'h3, 32'h1);
    want_chg <= 1'h1;
    go(8);
    st(32'h103, 32'h102);
    want_chg <= 1'h0;
    want_load <= 1'h1;
    go(8);
    st(32'h3, 32'h3);
    soc_q = '{24, 25, 50, 75};
    repeat (4) soc_q.push_back(int'($urandom % 96));
    foreach (soc_q[i]) begin
      wr({28'h0, ADDR_SOC}, 32'(soc_q[i]));
      go(3);
      chk({28'h0, cap}, lamps(soc_q[i]));
    end
    cell_ov_det <= 1'h1;
    go(6);
    st(32'h4, 32'h4);
    cell_ov_det <= 1'h0;
    go(6);
    st(32'h7, 32'h3);
    dsg_fault <= 1'h1;
    go(8);
    chk({26'h0, dsg_enable, fault_lamp_out, cap}, 32'h10);
    dsg_fault <= 1'h0;
    want_load <= 1'h0;
    go(10);
    st(32'h3, 32'h1);
    cell_ov_det <= 1'h1;
    pack_ov_det <= 1'h1;
    go(6);
    st(32'h10C, 32'hC);
    pack_ov_det <= 1'h0;
    pack_ov_clr <= 1'h1;
    go(6);
    st(32'h10C, 32'h4);
    cell_ov_det <= 1'h0;
    cell_ov_clr <= 1'h1;
    go(6);
    st(32'h10C, 32'h100);
    {cell_ov_clr, pack_ov_clr} <= 2'h0;
    go(90);
    st(32'h3, 32'h0);
    wake_48v <= 1'h1;
    go(8);
    wake_48v <= 1'h0;
    st(32'h3, 32'h1);
    wr({28'h0, ADDR_CTRL}, 32'h3);
    go(3);
    st(32'h3, 32'h0);
    ext_switch <= 1'h1;
    go(8);
    st(32'h3, 32'h1);
    key_off <= 1'h1;
    go(8);
    key_off <= 1'h0;
    st(32'h3, 32'h0);
    key_on <= 1'h1;
    pack_uv_det <= 1'h1;
    go(8);
    key_on <= 1'h0;
    st(32'h220, 32'h20);
    go(40);
    pack_uv_det <= 1'h0;
    st(32'h3, 32'h0);
    chk({31'h0, power_hold}, 32'h0);
    reset_key <= 1'h1;
    go(6);
    reset_key <= 1'h0;
    st(32'h240, 32'h40);
    chk({31'h0, power_hold}, 32'h1);
    complete_run();
  end
  initial begin
    go(4000);
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end
endmodule // testbench
`default_nettype wire
